// file: acr_ctrl.sv
// converter control registers with wishbone slave and interrupt
`timescale 1ns/1ps
module acr_ctrl
    import acr_pkg::*;
#(
    parameter int CONV_CLKS = ACR_CONV_CLKS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // analogue core side
    input wire logic [11:0] conv_result_i,
    output logic power_en_o,
    output logic bandgap_en_o,
    output logic ext_en_o,
    output logic [3:0] channel_o,
    output logic [1:0] vref_sel_o,
    // interrupt
    output logic irq_o
);
    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] start_channel_r;
    logic [7:0] source_ref_clock_r;
    logic [11:0] result_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_stat_nxt;
    acr_state_t state_r;
    acr_state_t state_nxt;
    logic busy_r;
    logic conv_done;

    // decoded selection
    logic req;
    logic wr;
    logic wr_lane0;
    logic hit_ctrl0;
    logic hit_ctrl1;
    logic hit_stat;
    logic hit_mask;
    logic hit_res_lo;
    logic hit_res_hi;
    logic [7:0] wdata;
    logic [7:0] ctrl0_nxt;
    logic start_bit;
    logic start_fall;
    logic power_en;
    logic align;
    logic [7:0] res_lo;
    logic [7:0] res_hi;
    logic [31:0] rdata;
    acr_route_t route;
    logic [1:0] events;

    // decode source and channel into the analogue routing
    function automatic acr_route_t route_of(input logic [2:0] src,
                                            input logic [3:0] ch);
        acr_route_t r;
        r.channel = ch;
        r.ext_en = (src == ACR_SRC_EXT0) || (src >= ACR_SRC_EXT_LO);
        r.bandgap_en = (src == ACR_SRC_BANDGAP);
        // channel switch closes for codes 0..11 with either source
        if (r.bandgap_en)
            r.ext_en = (ch <= ACR_CH_LAST);
        else if (r.ext_en)
            r.ext_en = (ch <= ACR_CH_LAST);
        // reserved codes route nothing
        return r;
    endfunction : route_of

    // ************************************************************
    // bus decode
    // ************************************************************
    assign req = cyc_i && stb_i && !ack_o;
    // writes land on the edge that shows ack, while the master still holds
    assign wr = cyc_i && stb_i && we_i && ack_o;
    assign wr_lane0 = wr && sel_i[0];
    assign hit_ctrl0 = ({2'b00, ACR_OFS_START_CHANNEL} == adr_i);
    assign hit_ctrl1 = ({2'b00, ACR_OFS_SOURCE_REF_CLOCK} == adr_i);
    assign hit_stat = (ACR_OFS_IRQ_STATUS == adr_i);
    assign hit_mask = (ACR_OFS_IRQ_MASK == adr_i);
    assign hit_res_lo = (adr_i == {2'b00, ACR_OFS_RESULT_LOW});
    assign hit_res_hi = (adr_i == {2'b00, ACR_OFS_RESULT_HIGH});
    assign wdata = dat_i[7:0];

    // ************************************************************
    // control fields
    // ************************************************************
    assign start_bit = start_channel_r[ACR_BIT_START];
    assign power_en = start_channel_r[ACR_BIT_POWER];
    assign align = start_channel_r[ACR_BIT_ALIGN];
    // busy is read-only: writes never touch it
    assign ctrl0_nxt = {wdata[7], busy_r, wdata[5:0]};
    // conversion starts on the falling half of the start pulse
    assign start_fall = wr_lane0 && hit_ctrl0 && start_bit && !wdata[7];
    assign route = route_of(source_ref_clock_r[7:ACR_SRC_LSB],
                            start_channel_r[3:0]);

    // result layout; unused bits read zero
    assign res_hi = align ? {4'h0, result_r[11:8]} : result_r[11:4];
    assign res_lo = align ? result_r[7:0] : {result_r[3:0], 4'h0};

    // read multiplexer; unmapped addresses read zero
    assign rdata = hit_ctrl0 ? {24'h0, start_channel_r[7],
                                busy_r, start_channel_r[5:0]} :
                   hit_ctrl1 ? {24'h0, source_ref_clock_r} :
                   hit_res_lo ? {24'h0, res_lo} :
                   hit_res_hi ? {24'h0, res_hi} :
                   hit_stat ? {30'h0, irq_stat_r} :
                   hit_mask ? {30'h0, irq_mask_r} : 32'h0;

    // ************************************************************
    // conversion sequencer
    // ************************************************************
    // armed: a high start bit has been written while powered; converting after its falling write; idle otherwise
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ACR_IDLE: begin
                if (wr_lane0 && hit_ctrl0 && wdata[7] && power_en)
                    state_nxt = ACR_ARMED;
            end
            ACR_ARMED: begin
                if (!power_en)
                    state_nxt = ACR_IDLE;
                else if (start_fall)
                    state_nxt = ACR_CONV;
            end
            ACR_CONV: begin
                if (!power_en || conv_done)
                    state_nxt = ACR_IDLE;
            end
            default: state_nxt = ACR_IDLE;
        endcase
    end

    // events: bit 0 conversion done, bit 1 bandgap with live pin
    assign events = {route.bandgap_en && route.ext_en,
                     conv_done && state_r == ACR_CONV};
    // set wins over a write-one clear in the same cycle
    assign irq_stat_nxt = (irq_stat_r &
                           ~((wr_lane0 && hit_stat) ? wdata[1:0] : 2'h0))
                          | events;

    acr_conv_timer #(
        .CONV_CLKS(CONV_CLKS)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(state_r == ACR_CONV),
        .div_sel_i(source_ref_clock_r[2:0]),
        .done_o(conv_done)
    );

    // register file, busy flag and result capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_channel_r <= ACR_CTRL_RESET;
            source_ref_clock_r <= ACR_CTRL_RESET;
            result_r <= 12'h000;
            irq_stat_r <= ACR_IRQ_RESET;
            irq_mask_r <= ACR_IRQ_RESET;
            state_r <= ACR_IDLE;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r <= (state_nxt == ACR_CONV);
            irq_stat_r <= irq_stat_nxt;
            if (wr_lane0 && hit_ctrl0)
                start_channel_r <= ctrl0_nxt;
            if (wr_lane0 && hit_ctrl1)
                source_ref_clock_r <= wdata;
            if (wr_lane0 && hit_mask)
                irq_mask_r <= wdata[1:0];
            // result clears while powered down
            if (!power_en)
                result_r <= 12'h000;
            else if (conv_done && state_r == ACR_CONV)
                result_r <= conv_result_i;
        end
    end

    // bus answer and registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
            irq_o <= 1'b0;
            power_en_o <= 1'b0;
            bandgap_en_o <= 1'b0;
            ext_en_o <= 1'b0;
            channel_o <= 4'h0;
            vref_sel_o <= 2'h0;
        end else begin
            ack_o <= req;
            dat_o <= req ? rdata : 32'h0;
            irq_o <= |(irq_stat_nxt & irq_mask_r);
            power_en_o <= power_en;
            bandgap_en_o <= route.bandgap_en;
            ext_en_o <= route.ext_en;
            channel_o <= route.channel;
            vref_sel_o <= source_ref_clock_r[4:3];
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_pulse_fall;
        state_r == ACR_ARMED ##0 start_fall ##0 power_en;
    endsequence

    // a conversion ends when the timer fires while converting
    sequence s_conv_end;
        state_r == ACR_CONV ##0 conv_done;
    endsequence

    a_start_sets_busy: assert property (
        s_pulse_fall |=> busy_r)
        else $error("busy not set after start pulse");
    a_rise_no_busy: assert property (
        (state_r == ACR_IDLE && !start_fall) |=> !busy_r)
        else $error("busy set without full pulse");
    a_done_clears_busy: assert property (
        s_conv_end |=> !busy_r && irq_stat_r[0])
        else $error("done did not clear busy or raise flag");
    a_bandgap_route: assert property (
        (source_ref_clock_r[7:5] == ACR_SRC_BANDGAP) |=> bandgap_en_o)
        else $error("bandgap not routed");
    a_ext_route: assert property (
        (source_ref_clock_r[7:5] == ACR_SRC_EXT0
         && start_channel_r[3:2] != 2'b11) |=> ext_en_o && !bandgap_en_o)
        else $error("external channel not routed");
    a_float_code: assert property (
        (start_channel_r[3:2] == 2'b11) |=> !ext_en_o)
        else $error("pin connected for 11xx code");
    a_reserved_none: assert property (
        (source_ref_clock_r[7:5] inside {3'h2, 3'h3, 3'h4})
        |=> !ext_en_o && !bandgap_en_o)
        else $error("reserved source routed a signal");
    a_align_right: assert property (
        align |-> res_hi[7:4] == 4'h0 && res_lo == result_r[7:0])
        else $error("right alignment layout wrong");
    a_align_left: assert property (
        !align |-> res_lo[3:0] == 4'h0 && res_hi == result_r[11:4])
        else $error("left alignment layout wrong");
    // the output is one cycle behind a mask write, so only a steady mask
    // lets it be compared against the status bits directly
    a_irq_level: assert property (
        $stable(irq_mask_r) |-> irq_o == |(irq_stat_r & irq_mask_r))
        else $error("interrupt output does not follow status");

    // bus handshake: one answer per request, data only beside it
    a_ack_answer: assert property (
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not answered");
    a_ack_pulse: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_dat_idle: assert property (
        !ack_o |-> dat_o == 32'h0)
        else $error("read data shown without ack");

    // read-back on the bus
    a_busy_readback: assert property (
        (req && !we_i && hit_ctrl0) |=> dat_o[ACR_BIT_BUSY] == $past(busy_r))
        else $error("busy flag not read back");
    a_res_hi_pad: assert property (
        (req && !we_i && hit_res_hi && align) |=> dat_o[7:4] == 4'h0)
        else $error("upper nibble of high byte not zero");
    a_res_lo_pad: assert property (
        (req && !we_i && hit_res_lo && !align) |=> dat_o[3:0] == 4'h0)
        else $error("lower nibble of low byte not zero");

    // conversion side effects
    a_abort_idle: assert property (
        (state_r == ACR_CONV && !power_en) |=> !busy_r)
        else $error("busy kept after power down");
    a_live_pin_flag: assert property (
        (route.bandgap_en && route.ext_en) |=> irq_stat_r[1])
        else $error("live pin with bandgap not flagged");
    a_result_cleared: assert property (
        !power_en |=> result_r == 12'h000)
        else $error("result kept while powered down");
endmodule : acr_ctrl

// file: acr_pkg.sv
// package: register map, field layout and encodings of the converter control
package acr_pkg;

    // ************************************************************
    // register offsets (byte addresses on the wishbone bus)
    // ************************************************************
    localparam logic [3:0] ACR_OFS_START_CHANNEL = 4'h0;
    localparam logic [3:0] ACR_OFS_SOURCE_REF_CLOCK = 4'h4;
    localparam logic [3:0] ACR_OFS_RESULT_LOW = 4'h8;
    localparam logic [3:0] ACR_OFS_RESULT_HIGH = 4'hC;
    localparam logic [5:0] ACR_OFS_IRQ_STATUS = 6'h10;
    localparam logic [5:0] ACR_OFS_IRQ_MASK = 6'h14;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int ACR_BIT_START = 7;
    localparam int ACR_BIT_BUSY = 6;
    localparam int ACR_BIT_POWER = 5;
    localparam int ACR_BIT_ALIGN = 4;
    localparam int ACR_SRC_LSB = 5;
    localparam logic [7:0] ACR_CTRL_RESET = 8'h00;
    localparam logic [1:0] ACR_IRQ_RESET = 2'h0;

    // ************************************************************
    // encodings
    // ************************************************************
    localparam logic [2:0] ACR_SRC_EXT0 = 3'h0;
    localparam logic [2:0] ACR_SRC_BANDGAP = 3'h1;
    localparam logic [2:0] ACR_SRC_EXT_LO = 3'h5;
    localparam logic [3:0] ACR_CH_LAST = 4'hB;
    localparam int ACR_CHANNELS = 12;

    // ************************************************************
    // timing: conversion length in converter clock periods
    // ************************************************************
    localparam int ACR_CONV_CLKS = 16;
    localparam logic [7:0] ACR_DIV_MAX = 8'h80;

    typedef enum logic [2:0] {
        ACR_IDLE = 3'b001,
        ACR_ARMED = 3'b010,
        ACR_CONV = 3'b100
    } acr_state_t;

    // converter routing selected by the control fields
    typedef struct packed {
        logic ext_en;
        logic bandgap_en;
        logic [3:0] channel;
    } acr_route_t;

endpackage : acr_pkg

// file: acr_conv_timer.sv
// conversion timer: counts converter clocks derived from the system clock
`timescale 1ns/1ps
module acr_conv_timer
    import acr_pkg::*;
#(
    parameter int CONV_CLKS = ACR_CONV_CLKS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic run_i,
    input wire logic [2:0] div_sel_i,
    // status
    output logic done_o
);
    logic [7:0] pre_r;
    logic [7:0] clks_r;
    logic [7:0] div_len;
    logic tick;

    // divider length 1,2,4..128 system clocks per converter clock
    assign div_len = 8'h01 << div_sel_i;
    assign tick = (pre_r == div_len - 8'h01);

    // prescaler and converter-clock counter restart whenever idle
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            pre_r <= 8'h00;
            clks_r <= 8'h00;
            done_o <= 1'b0;
        end else begin
            pre_r <= tick ? 8'h00 : pre_r + 8'h01;
            if (tick)
                clks_r <= clks_r + 8'h01;
            done_o <= tick && (clks_r == 8'(CONV_CLKS - 1));
        end
    end
endmodule : acr_conv_timer

// file: acr_ctrl_tb.sv
// testbench: register access, routing, conversion and interrupt of acr_ctrl
`timescale 1ns/1ps
module acr_ctrl_tb;
    import acr_pkg::*;
    // ************************************************************
    // signals, offsets and instance
    // ************************************************************
    localparam logic [5:0] A_SC = 6'(ACR_OFS_START_CHANNEL);
    localparam logic [5:0] A_SR = 6'(ACR_OFS_SOURCE_REF_CLOCK);
    localparam logic [5:0] A_RL = 6'(ACR_OFS_RESULT_LOW);
    localparam logic [5:0] A_RH = 6'(ACR_OFS_RESULT_HIGH);
    localparam logic [5:0] A_ST = ACR_OFS_IRQ_STATUS;
    localparam logic [5:0] A_MK = ACR_OFS_IRQ_MASK;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [5:0] adr_i = 6'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic [11:0] conv_result_i = 12'h000;
    logic power_en_o, bandgap_en_o, ext_en_o, irq_o;
    logic [3:0] channel_o;
    logic [1:0] vref_sel_o;
    int n_errors = 0;
    int tests_run = 0;

    // a short conversion keeps the run brief
    acr_ctrl #(.CONV_CLKS(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .conv_result_i(conv_result_i), .power_en_o(power_en_o),
        .bandgap_en_o(bandgap_en_o), .ext_en_o(ext_en_o),
        .channel_o(channel_o), .vref_sel_o(vref_sel_o), .irq_o(irq_o));

    // free-running system clock
    always #5 clk_i = ~clk_i;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // every signal changes right after a rising edge; ack is sampled at a
    // rising edge, read data is taken there, and only then is it released
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) chk("ack", 32'h0, 32'h1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] junk;
        xfer(1'b1, a, d, junk);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        xfer(1'b0, a, 8'h00, v);
    endtask : rd

    task automatic settle;
        repeat (2) @(negedge clk_i);
    endtask : settle

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        logic [31:0] v;
        rd(A_SC, v); chk("start_channel reset", v, 32'h0);
        rd(A_SR, v); chk("source_ref reset", v, 32'h0);
        rd(A_ST, v); chk("status reset", v, 32'h0);
        rd(A_MK, v); chk("mask reset", v, 32'h0);
        rd(6'h18, v); chk("unmapped read", v, 32'h0);
        wr(A_SC, 8'h4A); // busy bit is read-only
        rd(A_SC, v); chk("busy not writable", v, 32'h0A);
        $display("test reset done");
    endtask : t_reset

    // source written first, channel parked at 11xx in between, so no
    // transient live-pin state leaks into the next step
    task automatic t_route;
        logic [31:0] v;
        logic [3:0] ch;
        logic ext;
        for (int s = 0; s < 8; s++) begin
            for (int k = 0; k < 2; k++) begin
                ch = (k == 1) ? 4'hC : 4'h3;
                wr(A_SR, {s[2:0], s[1:0], 3'h0});
                wr(A_SC, {4'h0, ch});
                settle;
                ext = (ch <= ACR_CH_LAST) && (s < 2 || s > 4);
                chk("bandgap_en", bandgap_en_o, 32'(s == 1));
                chk("ext_en", ext_en_o, 32'(ext));
                chk("channel", channel_o, 32'(ch));
                chk("vref_sel", vref_sel_o, 32'(s[1:0]));
                rd(A_ST, v);
                chk("live pin flag", v[1], 32'(s == 1 && k == 0));
                wr(A_SC, 8'h0C);
                wr(A_ST, 8'h02);
            end
        end
        $display("test routing done");
    endtask : t_route

    task automatic t_conv(input logic al, input logic [11:0] r);
        logic [31:0] v;
        int n;
        wr(A_SR, 8'h03);
        conv_result_i <= r;
        wr(A_SC, {3'b001, al, 4'h2});
        wr(A_SC, {3'b101, al, 4'h2});
        repeat (40) @(negedge clk_i);
        rd(A_SC, v); chk("busy after rise only", v[6], 32'h0);
        wr(A_SC, {3'b001, al, 4'h2});
        rd(A_SC, v); chk("busy at start", v[6], 32'h1);
        n = 0;
        do begin
            rd(A_SC, v);
            n++;
        end while (v[6] === 1'b1 && n < 50);
        chk("busy cleared", v[6], 32'h0);
        conv_result_i <= ~r;
        rd(A_ST, v); chk("done flag", v, 32'h1);
        chk("irq masked", irq_o, 32'h0);
        wr(A_MK, 8'h01);
        settle;
        chk("irq unmasked", irq_o, 32'h1);
        wr(A_ST, 8'h01);
        settle;
        chk("irq cleared", irq_o, 32'h0);
        wr(A_MK, 8'h00);
        rd(A_RH, v);
        chk("result high", v, al ? {28'h0, r[11:8]} : {24'h0, r[11:4]});
        rd(A_RL, v);
        chk("result low", v, al ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0});
        wr(A_SC, 8'h00);
        rd(A_RH, v); chk("result cleared", v, 32'h0);
        $display("test conversion align %0d done", al);
    endtask : t_conv

    // ************************************************************
    // closing, watchdog and main sequence
    // ************************************************************
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // the tests need about five hundred cycles; this is ample headroom
    initial begin
        repeat (20000) @(posedge clk_i);
        chk("watchdog", 32'h1, 32'h0);
        summarize;
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_route;
        t_conv(1'b0, 12'hA5C);
        t_conv(1'b1, 12'h3C7);
        summarize;
    end
endmodule : acr_ctrl_tb
